/* hdl/flash_ctrl_pkg.sv */
package flash_ctrl_pkg;

    // ------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_UNLOCK_KEY = 8'h04;
    localparam logic [7:0] OFS_SECTOR_LOW = 8'h08;
    localparam logic [7:0] OFS_SECTOR_HIGH = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RESET_VECTOR = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // control register fields and codes
    // ------------------------------------------------------------
    localparam int CTL_START_BIT = 0;
    localparam int CTL_FAIL_BIT = 3;
    localparam int CTL_MODE_LSB = 4;
    localparam logic [3:0] MODE_ERASE = 4'hA;
    localparam logic [3:0] MODE_PROGRAM = 4'h5;
    localparam logic [3:0] MODE_HARD_LOCK = 4'h6;
    localparam logic [7:0] UNLOCK_KEY_VALUE = 8'hA5;
    localparam logic [7:0] UNLOCK_KEY_RESET = 8'h00;
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam logic [7:0] SECTOR_RESET = 8'h00;
    localparam int SECTOR_LOW_KEEP_BIT = 7;

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int STS_BUSY_BIT = 0;
    localparam int STS_HARD_LOCK_BIT = 1;
    localparam int STS_UNLOCKED_BIT = 2;
    localparam int STS_BOOT_ACTIVE_BIT = 3;

    // ------------------------------------------------------------
    // option byte fields
    // ------------------------------------------------------------
    localparam int OPT_SIZE_OFF_BIT = 2;
    localparam int OPT_BOOT_EN_BIT = 4;
    localparam int OPT_VEC_SEL_BIT = 7;
    localparam logic [7:0] OPT_RESET = 8'hFF;
    localparam logic [15:0] BOOT_BASE = 16'h0100;
    localparam logic [15:0] BOOT_END_256 = 16'h0200;
    localparam logic [15:0] BOOT_END_512 = 16'h0300;
    localparam logic [15:0] BOOT_END_1K = 16'h0500;
    localparam logic [15:0] BOOT_END_2K = 16'h0900;
    localparam logic [15:0] VEC_DEFAULT = 16'h0100;
    localparam logic [15:0] VEC_ALT_0 = 16'h0200;
    localparam logic [15:0] VEC_ALT_1 = 16'h0300;
    localparam logic [15:0] VEC_ALT_2 = 16'h0500;
    localparam logic [15:0] VEC_ALT_3 = 16'h0900;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int ERASE_TIME_MS = 10;
    localparam int ERASE_CYCLES_DEF = ERASE_TIME_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 20;

    typedef enum logic {ST_IDLE, ST_ERASE} erase_state_t;

endpackage

/* hdl/boot_option_decode.sv */
module boot_option_decode (
    // option byte
    input wire logic [7:0] opt_i,
    // decoded
    output logic boot_active_o,
    output logic [15:0] boot_end_o,
    output logic [15:0] reset_vector_o
);

    // ------------------------------------------------------------
    // boot area size
    // ------------------------------------------------------------
    always_comb begin
        // enable bit and size off bit both low mean the area is reserved
        boot_active_o = !opt_i[flash_ctrl_pkg::OPT_BOOT_EN_BIT] &&
                        !opt_i[flash_ctrl_pkg::OPT_SIZE_OFF_BIT];
        case (opt_i[1:0])
            2'h0: boot_end_o = flash_ctrl_pkg::BOOT_END_256;
            2'h1: boot_end_o = flash_ctrl_pkg::BOOT_END_512;
            2'h2: boot_end_o = flash_ctrl_pkg::BOOT_END_1K;
            default: boot_end_o = flash_ctrl_pkg::BOOT_END_2K;
        endcase
    end

    // ------------------------------------------------------------
    // reset vector, decoded from its own bits and the enable bit only
    // ------------------------------------------------------------
    always_comb begin
        reset_vector_o = flash_ctrl_pkg::VEC_DEFAULT;
        if (!opt_i[flash_ctrl_pkg::OPT_BOOT_EN_BIT] &&
            !opt_i[flash_ctrl_pkg::OPT_VEC_SEL_BIT]) begin
            case (opt_i[6:5])
                2'h0: reset_vector_o = flash_ctrl_pkg::VEC_ALT_0;
                2'h1: reset_vector_o = flash_ctrl_pkg::VEC_ALT_1;
                2'h2: reset_vector_o = flash_ctrl_pkg::VEC_ALT_2;
                default: reset_vector_o = flash_ctrl_pkg::VEC_ALT_3;
            endcase
        end
    end

endmodule

/* hdl/user_mode_flash_erase_program_ctrl.sv */
// Operation
// - erase or hard lock starts only on a write of one to control bit 0
// - byte read and program need only the load instruction, no start bit
// - interrupt request aborts a running erase; status bit is read only
// - erase status reads 0 on success, 1 on failure or abort
// - reset loads the unlock key with zero, user mode off
// - user mode is on only while the unlock key holds A5
// - control register accepts writes only while user mode is on
// - sector address is built from the high and low sector registers
// - sectors are 128 bytes; low sector bits 6 to 0 are ignored
// - option enable bit 0 with size off bit 2 also 0 reserves the boot area; 1 in either bit frees it
// - option bits 2 to 0 size the boot area from 100H
// - option bits 7 to 5 choose the power-on reset vector
// - alternative vector only when boot enable and vector select are 0
// - vector field and size field decode independently
// - sector erase exists only in user mode, not in tool mode
// - erase lasts at least 10 ms; software waits for it
// - tool mode may still program the boot area but cannot erase at all
// - upper nibble 0110 sets hard lock, blocking writes until chip erase
// - erase status sits at control bit 3
module user_mode_flash_erase_program_ctrl #(
    parameter int unsigned ERASE_CYCLES = flash_ctrl_pkg::ERASE_CYCLES_DEF
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // cpu load instruction port
    input wire logic pml_req_i,
    input wire logic pml_we_i,
    input wire logic [15:0] pml_addr_i,
    input wire logic [7:0] pml_wdata_i,
    output logic pml_ack_o,
    output logic [7:0] pml_rdata_o,
    // cpu interrupt request and chip level inputs
    input wire logic irq_i,
    input wire logic [7:0] option_byte_i,
    input wire logic tool_mode_i,
    input wire logic chip_erase_i,
    // flash array
    output logic flash_erase_o,
    output logic [15:0] flash_sector_o,
    output logic flash_rd_o,
    output logic flash_prog_o,
    output logic [15:0] flash_addr_o,
    output logic [7:0] flash_wdata_o,
    input wire logic [7:0] flash_rdata_i,
    // decoded options
    output logic [15:0] reset_vector_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] opt_meta_reg, opt_reg;
    logic tool_meta_reg, tool_reg, cerase_meta_reg, cerase_reg;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            opt_meta_reg <= flash_ctrl_pkg::OPT_RESET;
            opt_reg <= flash_ctrl_pkg::OPT_RESET;
            tool_meta_reg <= 1'b0;
            tool_reg <= 1'b0;
            cerase_meta_reg <= 1'b0;
            cerase_reg <= 1'b0;
        end else begin
            opt_meta_reg <= option_byte_i;
            opt_reg <= opt_meta_reg;
            tool_meta_reg <= tool_mode_i;
            tool_reg <= tool_meta_reg;
            cerase_meta_reg <= chip_erase_i;
            cerase_reg <= cerase_meta_reg;
        end
    end

    logic boot_active;
    logic [15:0] boot_end;

    boot_option_decode u_opt (
        .opt_i(opt_reg),
        .boot_active_o(boot_active),
        .boot_end_o(boot_end),
        .reset_vector_o(reset_vector_o)
    );

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] key_reg;
    logic [3:0] mode_reg;
    logic fail_reg, hard_lock_reg;
    logic sec_lo_reg;
    logic [7:0] sec_hi_reg;
    flash_ctrl_pkg::erase_state_t state_reg;
    logic [flash_ctrl_pkg::CNT_W-1:0] cnt_reg;
    logic unlocked, busy;
    logic [15:0] sector_base;
    logic [flash_ctrl_pkg::CNT_W-1:0] erase_last;

    assign unlocked = key_reg == flash_ctrl_pkg::UNLOCK_KEY_VALUE;
    assign busy = state_reg == flash_ctrl_pkg::ST_ERASE;
    assign sector_base = {sec_hi_reg, sec_lo_reg, 7'h00};
    assign erase_last = flash_ctrl_pkg::CNT_W'(ERASE_CYCLES - 1);

    // tool mode lifts the boot guard; boot area is aligned to 256 bytes
    function automatic logic in_boot(input logic [15:0] a);
        in_boot = boot_active && !tool_reg &&
                  a >= flash_ctrl_pkg::BOOT_BASE && a < boot_end;
    endfunction

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    logic aw_hold_reg, w_hold_reg, bvalid_reg;
    logic [7:0] waddr_reg;
    logic [7:0] wdata_reg;
    logic wstrb0_reg;
    logic wr_fire, wr_mapped, ctl_wr;

    assign s_axi_awready_o = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready_o = !w_hold_reg && !bvalid_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wr_mapped = waddr_reg == flash_ctrl_pkg::OFS_CONTROL ||
                       waddr_reg == flash_ctrl_pkg::OFS_UNLOCK_KEY ||
                       waddr_reg == flash_ctrl_pkg::OFS_SECTOR_LOW ||
                       waddr_reg == flash_ctrl_pkg::OFS_SECTOR_HIGH ||
                       waddr_reg == flash_ctrl_pkg::OFS_STATUS ||
                       waddr_reg == flash_ctrl_pkg::OFS_RESET_VECTOR;
    assign ctl_wr = wr_fire && wstrb0_reg &&
                    waddr_reg == flash_ctrl_pkg::OFS_CONTROL;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            waddr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
            s_axi_bresp_o <= flash_ctrl_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_hold_reg <= 1'b1;
                waddr_reg <= {s_axi_awaddr_i[7:2], 2'h0};
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata_i[7:0];
                wstrb0_reg <= s_axi_wstrb_i[0];
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                s_axi_bresp_o <= wr_mapped ? flash_ctrl_pkg::RESP_OKAY :
                                 flash_ctrl_pkg::RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready_i) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // key and sector registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            key_reg <= flash_ctrl_pkg::UNLOCK_KEY_RESET;
            sec_lo_reg <= 1'b0;
            sec_hi_reg <= flash_ctrl_pkg::SECTOR_RESET;
        end else if (wr_fire && wstrb0_reg) begin
            if (waddr_reg == flash_ctrl_pkg::OFS_UNLOCK_KEY)
                key_reg <= wdata_reg;
            if (waddr_reg == flash_ctrl_pkg::OFS_SECTOR_LOW)
                // only bit 7 selects within a 256 byte page
                sec_lo_reg <= wdata_reg[flash_ctrl_pkg::SECTOR_LOW_KEEP_BIT];
            if (waddr_reg == flash_ctrl_pkg::OFS_SECTOR_HIGH)
                sec_hi_reg <= wdata_reg;
        end
    end

    // ------------------------------------------------------------
    // control register, erase sequencer and hard lock
    // ------------------------------------------------------------
    logic start_wr;
    logic [3:0] wr_mode;

    assign wr_mode = wdata_reg[7:4];
    assign start_wr = ctl_wr && unlocked &&
                      wdata_reg[flash_ctrl_pkg::CTL_START_BIT];

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            mode_reg <= flash_ctrl_pkg::MODE_RESET;
        end else if (ctl_wr && unlocked) begin
            mode_reg <= wr_mode;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            hard_lock_reg <= 1'b0;
        end else if (cerase_reg) begin
            hard_lock_reg <= 1'b0;
        end else if (start_wr &&
                     wr_mode == flash_ctrl_pkg::MODE_HARD_LOCK) begin
            hard_lock_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_reg <= flash_ctrl_pkg::ST_IDLE;
            cnt_reg <= '0;
            fail_reg <= 1'b0;
        end else begin
            case (state_reg)
                flash_ctrl_pkg::ST_IDLE: begin
                    // refused starts leave the old status in place
                    if (start_wr && wr_mode == flash_ctrl_pkg::MODE_ERASE &&
                        !tool_reg && !hard_lock_reg &&
                        !in_boot(sector_base)) begin
                        state_reg <= flash_ctrl_pkg::ST_ERASE;
                        cnt_reg <= '0;
                        fail_reg <= 1'b1;
                    end
                end
                flash_ctrl_pkg::ST_ERASE: begin
                    if (irq_i) begin
                        state_reg <= flash_ctrl_pkg::ST_IDLE;
                        fail_reg <= 1'b1;
                    end else if (cnt_reg == erase_last) begin
                        state_reg <= flash_ctrl_pkg::ST_IDLE;
                        fail_reg <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: state_reg <= flash_ctrl_pkg::ST_IDLE;
            endcase
        end
    end

    assign flash_erase_o = busy;
    assign flash_sector_o = sector_base;

    // ------------------------------------------------------------
    // load instruction path: taken, then flash strobe, then ack
    // ------------------------------------------------------------
    logic prog_ok, rd_stage_reg;

    // a process, so option or tool changes seen inside in_boot re-run it
    always_comb begin
        prog_ok = pml_req_i && pml_we_i && unlocked &&
                  mode_reg == flash_ctrl_pkg::MODE_PROGRAM &&
                  !hard_lock_reg && !in_boot(pml_addr_i) &&
                  pml_addr_i[15:7] == sector_base[15:7];
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            flash_rd_o <= 1'b0;
            flash_prog_o <= 1'b0;
            flash_addr_o <= 16'h0000;
            flash_wdata_o <= 8'h00;
            rd_stage_reg <= 1'b0;
            pml_ack_o <= 1'b0;
            pml_rdata_o <= 8'h00;
        end else begin
            flash_rd_o <= pml_req_i && !pml_we_i;
            flash_prog_o <= prog_ok;
            rd_stage_reg <= pml_req_i;
            pml_ack_o <= rd_stage_reg;
            if (pml_req_i) begin
                flash_addr_o <= pml_addr_i;
                flash_wdata_o <= pml_wdata_i;
            end
            if (flash_rd_o)
                pml_rdata_o <= flash_rdata_i;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    logic rvalid_reg;
    logic [7:0] raddr;

    assign s_axi_arready_o = !rvalid_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign raddr = {s_axi_araddr_i[7:2], 2'h0};

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rvalid_reg <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= flash_ctrl_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_reg <= 1'b1;
            s_axi_rresp_o <= flash_ctrl_pkg::RESP_OKAY;
            s_axi_rdata_o <= 32'h0000_0000;
            case (raddr)
                flash_ctrl_pkg::OFS_CONTROL:
                    s_axi_rdata_o[7:0] <= {mode_reg, fail_reg, 2'h0,
                                           busy};
                flash_ctrl_pkg::OFS_UNLOCK_KEY:
                    s_axi_rdata_o[7:0] <= key_reg;
                flash_ctrl_pkg::OFS_SECTOR_LOW:
                    s_axi_rdata_o[7:0] <= {sec_lo_reg, 7'h00};
                flash_ctrl_pkg::OFS_SECTOR_HIGH:
                    s_axi_rdata_o[7:0] <= sec_hi_reg;
                flash_ctrl_pkg::OFS_STATUS:
                    s_axi_rdata_o[3:0] <= {boot_active, unlocked,
                                           hard_lock_reg, busy};
                flash_ctrl_pkg::OFS_RESET_VECTOR:
                    s_axi_rdata_o[15:0] <= reset_vector_o;
                default:
                    s_axi_rresp_o <= flash_ctrl_pkg::RESP_SLVERR;
            endcase
        end else if (rvalid_reg && s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    erase_needs_start_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        $rose(busy) |-> $past(start_wr) &&
                        $past(wr_mode) == flash_ctrl_pkg::MODE_ERASE)
        else $error("erase began without a start write");

    pml_program_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        prog_ok |=> flash_prog_o ##1 pml_ack_o)
        else $error("allowed load write did not program");

    irq_abort_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        busy && irq_i |=> !busy && fail_reg)
        else $error("interrupt did not abort the erase");

    erase_ok_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        busy && !irq_i && cnt_reg == erase_last |=> !busy && !fail_reg)
        else $error("finished erase not reported as success");

    key_reset_a: assert property (
        @(posedge clk_sys_i)
        sys_rst_i |=> key_reg == 8'h00 && !flash_prog_o)
        else $error("unlock key not cleared by reset");

    locked_write_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        pml_req_i && !unlocked |=> !flash_prog_o)
        else $error("programmed while locked");

    ctl_locked_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        ctl_wr && !unlocked |=> $stable(mode_reg) && !$rose(busy))
        else $error("control changed while locked");

    sector_align_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        flash_sector_o[6:0] == 7'h00)
        else $error("sector address not aligned");

    boot_guard_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        flash_prog_o |-> !in_boot(flash_addr_o))
        else $error("boot area programmed");

    erase_time_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        $fell(busy) && !$past(irq_i) |-> $past(cnt_reg) == erase_last)
        else $error("erase ended early");

    hard_lock_a: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        hard_lock_reg |-> !prog_ok ##1 !$rose(busy))
        else $error("flash changed under hard lock");

endmodule

/* tb/flash_array_model.sv */
module flash_array_model (
    // array side
    input wire logic clk_i,
    input wire logic rd_i,
    input wire logic prog_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    // idle lines show the inverted last byte, so stale data never matches
    assign rdata_o = rd_i ? mem[addr_i[7:0]] : ~last;
    always @(posedge clk_i) begin
        if (prog_i) mem[addr_i[7:0]] <= wdata_i;
        if (rd_i) last <= mem[addr_i[7:0]];
    end
endmodule

/* tb/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_sys_i = 1'b0, sys_rst_i = 1'b1;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, pml_req_i = 1'b0;
    logic pml_we_i = 1'b0, irq_i = 1'b0, tool_mode_i = 1'b0;
    logic chip_erase_i = 1'b0;
    logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [7:0] pml_wdata_i = 8'h00, option_byte_i = 8'hFF, flash_rdata_i;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic [15:0] pml_addr_i = 16'h0000, flash_sector_o, flash_addr_o;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic s_axi_rvalid_o, pml_ack_o, flash_erase_o, flash_rd_o, flash_prog_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [7:0] pml_rdata_o, flash_wdata_o;
    logic [15:0] reset_vector_o;
    int err_total = 0, tests_run = 0;
    // short count keeps the erase wait small
    localparam int EC = 20;
    localparam logic [7:0] CTL = flash_ctrl_pkg::OFS_CONTROL;
    localparam logic [7:0] KEY = flash_ctrl_pkg::OFS_UNLOCK_KEY;
    localparam logic [7:0] SLO = flash_ctrl_pkg::OFS_SECTOR_LOW;
    localparam logic [7:0] SHI = flash_ctrl_pkg::OFS_SECTOR_HIGH;
    localparam logic [7:0] STS = flash_ctrl_pkg::OFS_STATUS;
    localparam bit [15:0] VEC[4] = '{16'h0200, 16'h0300, 16'h0500, 16'h0900};
    user_mode_flash_erase_program_ctrl #(.ERASE_CYCLES(EC))
        user_mode_flash_erase_program_ctrl_inst (.*);
    flash_array_model flash_array_model_inst (.clk_i(clk_sys_i),
        .rd_i(flash_rd_o), .prog_i(flash_prog_o), .addr_i(flash_addr_o),
        .wdata_i(flash_wdata_o), .rdata_o(flash_rdata_i));
    initial forever #5 clk_sys_i = ~clk_sys_i;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] er = 2'h0);
        logic ha, hw, hb;
        logic [1:0] r;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= {24'h0, d};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do begin
            // ready sampled mid-cycle equals its value at the next edge
            @(negedge clk_sys_i);
            ha = s_axi_awvalid_i && s_axi_awready_o;
            hw = s_axi_wvalid_i && s_axi_wready_o;
            hb = s_axi_bready_i && s_axi_bvalid_o;
            if (hb) r = s_axi_bresp_o;
            @(posedge clk_sys_i);
            if (ha) s_axi_awvalid_i <= 1'b0;
            if (hw) s_axi_wvalid_i <= 1'b0;
            if (hb) s_axi_bready_i <= 1'b0;
        end while (s_axi_awvalid_i || s_axi_wvalid_i || s_axi_bready_i);
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = 2'h0);
        logic ha, hr;
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do begin
            @(negedge clk_sys_i);
            ha = s_axi_arvalid_i && s_axi_arready_o;
            hr = s_axi_rready_i && s_axi_rvalid_o;
            if (hr) chk("rdata", e, s_axi_rdata_o);
            if (hr) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp_o});
            @(posedge clk_sys_i);
            if (ha) s_axi_arvalid_i <= 1'b0;
            if (hr) s_axi_rready_i <= 1'b0;
        end while (s_axi_arvalid_i || s_axi_rready_i);
    endtask
    task automatic ld(input logic w, input logic [15:0] a, input logic [7:0] d,
                      input logic ep, input logic [7:0] er = 8'h00);
        pml_req_i <= 1'b1;
        pml_we_i <= w;
        pml_addr_i <= a;
        pml_wdata_i <= d;
        @(posedge clk_sys_i);
        pml_req_i <= 1'b0;
        @(negedge clk_sys_i);
        chk("flash_prog_o", {31'h0, ep}, {31'h0, flash_prog_o});
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk("pml_ack_o", 32'h1, {31'h0, pml_ack_o});
        if (!w) chk("pml_rdata_o", {24'h0, er}, {24'h0, pml_rdata_o});
        @(posedge clk_sys_i);
    endtask
    task automatic opt(input logic [7:0] v);
        option_byte_i <= v;
        repeat (4) @(posedge clk_sys_i);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        #50000;
        err_total++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        rd(KEY, 32'h0);
        wr(CTL, 8'hA1);
        rd(CTL, 32'h0);
        wr(KEY, 8'hA4);
        wr(CTL, 8'h51);
        rd(CTL, 32'h0);
        wr(8'h20, 8'h00, 2'h2);
        rd(8'h20, 32'h0, 2'h2);
        $display("reset and key test done");
        wr(KEY, 8'hA5);
        wr(SHI, 8'h10);
        wr(SLO, 8'hFF);
        rd(SLO, 32'h80);
        chk("flash_sector_o", 32'h1080, {16'h0, flash_sector_o});
        wr(CTL, 8'h51);
        ld(1'b1, 16'h1085, 8'h5A, 1'b1);
        ld(1'b1, 16'h1105, 8'h33, 1'b0);
        ld(1'b0, 16'h1085, 8'h00, 1'b0, 8'h5A);
        $display("program test done");
        wr(CTL, 8'hA0);
        rd(STS, 32'h4);
        wr(CTL, 8'hA1);
        rd(CTL, 32'hA9);
        repeat (EC / 2) @(posedge clk_sys_i);
        chk("flash_erase_o", 32'h1, {31'h0, flash_erase_o});
        repeat (EC / 2) @(posedge clk_sys_i);
        rd(CTL, 32'hA0);
        wr(CTL, 8'hA1);
        irq_i <= 1'b1;
        @(posedge clk_sys_i);
        irq_i <= 1'b0;
        rd(CTL, 32'hA8);
        $display("erase test done");
        opt(8'h00);
        wr(CTL, 8'h51);
        wr(SHI, 8'h01);
        ld(1'b1, 16'h0180, 8'h11, 1'b0);
        tool_mode_i <= 1'b1;
        opt(8'h00);
        wr(CTL, 8'hA1);
        rd(CTL, 32'hA8);
        wr(CTL, 8'h51);
        ld(1'b1, 16'h0181, 8'h22, 1'b1);
        tool_mode_i <= 1'b0;
        opt(8'h10);
        ld(1'b1, 16'h0182, 8'h33, 1'b1);
        opt(8'h04);
        ld(1'b1, 16'h0183, 8'h44, 1'b1);
        wr(SHI, 8'h08);
        opt(8'h03);
        ld(1'b1, 16'h08FF, 8'h55, 1'b0);
        opt(8'h02);
        ld(1'b1, 16'h08FE, 8'h66, 1'b1);
        for (int i = 0; i < 4; i++) begin
            opt({1'b0, 2'(i), 3'h0, ~2'(i)});
            chk("reset_vector_o", {16'h0, VEC[i]},
                {16'h0, reset_vector_o});
        end
        opt(8'h10);
        chk("reset_vector_o", 32'h0100, {16'h0, reset_vector_o});
        rd(8'h14, 32'h0100);
        $display("boot area test done");
        opt(8'hFF);
        wr(CTL, 8'h61);
        rd(STS, 32'h6);
        wr(CTL, 8'h51);
        ld(1'b1, 16'h0881, 8'h77, 1'b0);
        chip_erase_i <= 1'b1;
        opt(8'hFF);
        chip_erase_i <= 1'b0;
        opt(8'hFF);
        rd(STS, 32'h4);
        wr(KEY, 8'h00);
        ld(1'b1, 16'h0882, 8'h88, 1'b0);
        $display("lock test done");
        complete_run();
    end
endmodule
